// *** prs_board_model.sv ***
/*
 * Board-side model of the reset source: drives the active-low power-on reset pin.
 * Assumes the bench steps it through drive() and that both share the reference clock.
 */
`timescale 1ns/10ps
module prs_board_model #(
	parameter int SETTLE_CYC = 16
) (
	input  wire logic ref_clk_in,
	output logic      external_por_n_out
);
	int settle_cnt = 0;

	initial external_por_n_out = 1'b0;

	// stands in for slow clock and oscillator settling; the real wait is far too long to run
	always @(posedge ref_clk_in) begin
		if (settle_cnt < SETTLE_CYC) begin
			settle_cnt <= settle_cnt + 1;
		end
	end

	// level is held for n edges, so a following call never stretches the pulse
	task automatic drive(input logic lvl, input int n);
		wait (settle_cnt >= SETTLE_CYC);
		@(posedge ref_clk_in);
		external_por_n_out <= lvl;
		repeat (n - 1) @(posedge ref_clk_in);
	endtask
endmodule

// *** prs_filt_if.sv ***
/*
 * Carries the filtered external reset from the glitch filter to the sequencer.
 * Assumes both ends run on the same reference clock.
 */
`timescale 1ns/10ps
interface prs_filt_if;
	logic rst_active;
	logic rst_assert;

	modport filt (output rst_active, output rst_assert);
	modport seq  (input  rst_active, input  rst_assert);
endinterface

// *** prs_pkg.sv ***
/*
 * Shared constants and types of the power-on reset sequencer.
 * Assumes a single 100 MHz reference clock drives all sequencer logic.
 */
package prs_pkg;

	// clock of the sequencer logic
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

	// low pulses on the external reset up to this length are ignored
	localparam int FILT_NS  = 208;
	localparam int FILT_CYC = FILT_NS / CLK_NS + 1;
	localparam int FILT_W   = 5;

	// pll power-down stays high for more than this after the filtered reset
	localparam int PD_MIN_NS = 1000;
	localparam int PD_CYC    = PD_MIN_NS / CLK_NS + 1;

	// pll reset low time
	localparam int PLLRST_NS  = 10600;
	localparam int PLLRST_CYC = (PLLRST_NS + CLK_NS - 1) / CLK_NS;

	// pll lock wait before the clock-generation reset is released
	localparam int LOCK_US  = 1330;
	localparam int LOCK_CYC = (LOCK_US * 1000 + CLK_NS - 1) / CLK_NS;

	// module reset follows the clock-generation reset by a count of oscillator cycles
	localparam int REF_HZ      = 24_000_000;
	localparam int MOD_REF_CYC = 256;
	localparam int MOD_CYC     = (MOD_REF_CYC * (CLK_HZ / 1000) + REF_HZ / 1000 - 1)
		/ (REF_HZ / 1000);

	localparam int SEQ_CNT_W = 18;

	// reset values of the sequence outputs
	localparam logic PLL_PD_RST     = 1'b1;
	localparam logic PLL_RST_N_RST  = 1'b0;
	localparam logic CHIP_RST_N_RST = 1'b0;
	localparam logic MOD_RST_N_RST  = 1'b0;

	typedef enum logic [2:0] {
		ST_HOLD   = 3'b000,
		ST_PD     = 3'b001,
		ST_PLLRST = 3'b010,
		ST_LOCK   = 3'b011,
		ST_CLKGEN = 3'b100,
		ST_RUN    = 3'b101
	} prs_state_type;

endpackage

// *** prs_por_filter.sv ***
/*
 * Synchroniser and glitch filter for the active-low external reset pin.
 * Assumes the pin is asynchronous to the reference clock.
 */
`timescale 1ns/10ps
module prs_por_filter (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic external_por_n_in,
	prs_filt_if.filt  filt_if
);
	import prs_pkg::*;

	logic              sync1_reg;
	logic              sync2_reg;
	logic              active_reg;
	logic              assert_reg;
	logic [FILT_W-1:0] run_cnt_reg;
	logic              want_active;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= external_por_n_in;
			sync2_reg <= sync1_reg;
		end
	end

	assign want_active = ~sync2_reg;

	// a level must persist past the glitch window before it is accepted, both ways
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			active_reg  <= 1'b1;
			assert_reg  <= 1'b0;
			run_cnt_reg <= '0;
		end else begin
			assert_reg <= 1'b0;
			if (want_active == active_reg) begin
				run_cnt_reg <= '0;
			end else if (run_cnt_reg == FILT_W'(FILT_CYC - 1)) begin
				active_reg  <= want_active;
				assert_reg  <= want_active;
				run_cnt_reg <= '0;
			end else begin
				run_cnt_reg <= run_cnt_reg + FILT_W'(1);
			end
		end
	end

	assign filt_if.rst_active = active_reg;
	assign filt_if.rst_assert = assert_reg;

	property p_filt_ignore;
		@(posedge ref_clk_in) disable iff (rst_in)
		$rose(active_reg) |-> ($past(sync2_reg, 1) == 1'b0 && $past(sync2_reg, 21) == 1'b0);
	endproperty
	a_filt_ignore: assert property (p_filt_ignore) else $error("reset accepted too early");

	property p_filt_pulse;
		@(posedge ref_clk_in) disable iff (rst_in)
		$rose(active_reg) |-> assert_reg ##1 !assert_reg;
	endproperty
	a_filt_pulse: assert property (p_filt_pulse) else $error("assert pulse wrong");

	property p_cov_glitch;
		@(posedge ref_clk_in) disable iff (rst_in)
		!active_reg && run_cnt_reg == FILT_W'(10) ##1 run_cnt_reg == '0 && !active_reg;
	endproperty
	c_cov_glitch: cover property (p_cov_glitch);

endmodule

// *** prs_sequencer.sv ***
/*
 * Power-on reset sequencer: filtered external reset, pll power-down, pll
 * reset, pll lock wait, clock-generation reset release, module reset release.
 * Assumes the oscillator and slow clock are stable before the pin is released.
 */
`timescale 1ns/10ps
module prs_sequencer #(
	parameter int unsigned LOCK_CYCLES = prs_pkg::LOCK_CYC
) (
	input  wire logic           ref_clk_in,
	input  wire logic           rst_in,
	input  wire logic           external_por_n_in,
	output logic                sys_rst_n_out,
	output logic                pll_pd_out,
	output logic                pll_rst_n_out,
	output logic                chip_rst_n_out,
	output logic                module_rst_n_out,
	output prs_pkg::prs_state_type seq_state_out
);
	import prs_pkg::*;

	prs_filt_if filt_if ();

	prs_state_type        state_reg;
	logic [SEQ_CNT_W-1:0] cnt_reg;
	logic                 sys_rst_n_reg;
	logic                 pll_pd_reg;
	logic                 pll_rst_n_reg;
	logic                 chip_rst_n_reg;
	logic                 mod_rst_n_reg;
	logic                 cnt_last;

	prs_por_filter prs_por_filter_inst (
		.ref_clk_in        (ref_clk_in),
		.rst_in            (rst_in),
		.external_por_n_in (external_por_n_in),
		.filt_if           (filt_if.filt)
	);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sys_rst_n_reg <= 1'b0;
		end else begin
			sys_rst_n_reg <= ~filt_if.rst_active;
		end
	end

	// the phase length is the compare value plus one, so each phase is exact
	always_comb begin
		cnt_last = 1'b0;
		case (state_reg)
			ST_PD:     cnt_last = (cnt_reg == SEQ_CNT_W'(PD_CYC - 1));
			ST_PLLRST: cnt_last = (cnt_reg == SEQ_CNT_W'(PLLRST_CYC - 1));
			ST_LOCK:   cnt_last = (cnt_reg == SEQ_CNT_W'(LOCK_CYCLES - 1));
			ST_CLKGEN: cnt_last = (cnt_reg == SEQ_CNT_W'(MOD_CYC - 1));
			default:   cnt_last = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= ST_HOLD;
			cnt_reg   <= '0;
		end else if (filt_if.rst_active) begin
			// any accepted low, at any step, parks the sequence at the start
			state_reg <= ST_HOLD;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				ST_HOLD: begin
					state_reg <= ST_PD;
					cnt_reg   <= '0;
				end
				ST_PD: begin
					if (cnt_last) begin
						state_reg <= ST_PLLRST;
						cnt_reg   <= '0;
					end else begin
						cnt_reg <= cnt_reg + SEQ_CNT_W'(1);
					end
				end
				ST_PLLRST: begin
					if (cnt_last) begin
						state_reg <= ST_LOCK;
						cnt_reg   <= '0;
					end else begin
						cnt_reg <= cnt_reg + SEQ_CNT_W'(1);
					end
				end
				ST_LOCK: begin
					if (cnt_last) begin
						state_reg <= ST_CLKGEN;
						cnt_reg   <= '0;
					end else begin
						cnt_reg <= cnt_reg + SEQ_CNT_W'(1);
					end
				end
				ST_CLKGEN: begin
					if (cnt_last) begin
						state_reg <= ST_RUN;
						cnt_reg   <= '0;
					end else begin
						cnt_reg <= cnt_reg + SEQ_CNT_W'(1);
					end
				end
				ST_RUN: begin
					cnt_reg <= '0;
				end
				default: begin
					state_reg <= ST_HOLD;
					cnt_reg   <= '0;
				end
			endcase
		end
	end

	// outputs follow the state on the same edge, from their own flops
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pll_pd_reg     <= PLL_PD_RST;
			pll_rst_n_reg  <= PLL_RST_N_RST;
			chip_rst_n_reg <= CHIP_RST_N_RST;
			mod_rst_n_reg  <= MOD_RST_N_RST;
		end else if (filt_if.rst_active) begin
			pll_pd_reg     <= PLL_PD_RST;
			pll_rst_n_reg  <= PLL_RST_N_RST;
			chip_rst_n_reg <= CHIP_RST_N_RST;
			mod_rst_n_reg  <= MOD_RST_N_RST;
		end else if (cnt_last) begin
			case (state_reg)
				ST_PD:     pll_pd_reg     <= 1'b0;
				ST_PLLRST: pll_rst_n_reg  <= 1'b1;
				ST_LOCK:   chip_rst_n_reg <= 1'b1;
				ST_CLKGEN: mod_rst_n_reg  <= 1'b1;
				default:   pll_pd_reg     <= pll_pd_reg;
			endcase
		end
	end

	assign sys_rst_n_out    = sys_rst_n_reg;
	assign pll_pd_out       = pll_pd_reg;
	assign pll_rst_n_out    = pll_rst_n_reg;
	assign chip_rst_n_out   = chip_rst_n_reg;
	assign module_rst_n_out = mod_rst_n_reg;
	assign seq_state_out    = state_reg;

	// helper: how many cycles the output vector has held its present value
	logic [3:0]           outs_now;
	logic [3:0]           outs_q;
	logic [SEQ_CNT_W-1:0] stable_cnt;

	assign outs_now = {pll_pd_reg, pll_rst_n_reg, chip_rst_n_reg, mod_rst_n_reg};

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			outs_q     <= {PLL_PD_RST, PLL_RST_N_RST, CHIP_RST_N_RST, MOD_RST_N_RST};
			stable_cnt <= SEQ_CNT_W'(1);
		end else begin
			outs_q <= outs_now;
			if (outs_now != outs_q) begin
				stable_cnt <= SEQ_CNT_W'(1);
			end else if (stable_cnt != '1) begin
				stable_cnt <= stable_cnt + SEQ_CNT_W'(1);
			end
		end
	end

	property p_pd_min;
		@(posedge ref_clk_in) disable iff (rst_in)
		(!pll_pd_reg && outs_q[3]) |-> stable_cnt >= SEQ_CNT_W'(PD_CYC);
	endproperty
	a_pd_min: assert property (p_pd_min) else $error("pll power-down too short");

	property p_pllrst_len;
		@(posedge ref_clk_in) disable iff (rst_in)
		(pll_rst_n_reg && !outs_q[2]) |-> stable_cnt == SEQ_CNT_W'(PLLRST_CYC);
	endproperty
	a_pllrst_len: assert property (p_pllrst_len) else $error("pll reset length wrong");

	property p_lock_wait;
		@(posedge ref_clk_in) disable iff (rst_in)
		(chip_rst_n_reg && !outs_q[1]) |-> stable_cnt == SEQ_CNT_W'(LOCK_CYCLES);
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("lock wait length wrong");

	property p_mod_delay;
		@(posedge ref_clk_in) disable iff (rst_in)
		(mod_rst_n_reg && !outs_q[0]) |-> stable_cnt == SEQ_CNT_W'(MOD_CYC) && chip_rst_n_reg;
	endproperty
	a_mod_delay: assert property (p_mod_delay) else $error("module reset delay wrong");

	property p_restart;
		@(posedge ref_clk_in) disable iff (rst_in)
		filt_if.rst_assert |=> state_reg == ST_HOLD && pll_pd_reg && !pll_rst_n_reg
			&& !chip_rst_n_reg && !mod_rst_n_reg;
	endproperty
	a_restart: assert property (p_restart) else $error("restart did not reset outputs");

	property p_order;
		@(posedge ref_clk_in) disable iff (rst_in)
		(mod_rst_n_reg |-> chip_rst_n_reg) and (chip_rst_n_reg |-> pll_rst_n_reg)
			and (pll_rst_n_reg |-> !pll_pd_reg);
	endproperty
	a_order: assert property (p_order) else $error("reset release order broken");

	property p_cov_run;
		@(posedge ref_clk_in) disable iff (rst_in)
		$rose(mod_rst_n_reg);
	endproperty
	c_cov_run: cover property (p_cov_run);

	property p_cov_abort;
		@(posedge ref_clk_in) disable iff (rst_in)
		state_reg == ST_LOCK ##1 state_reg == ST_HOLD;
	endproperty
	c_cov_abort: cover property (p_cov_abort);

	property p_cov_rerun;
		@(posedge ref_clk_in) disable iff (rst_in)
		state_reg == ST_RUN ##1 state_reg == ST_HOLD;
	endproperty
	c_cov_rerun: cover property (p_cov_rerun);

endmodule

// *** test_power_on_reset_sequencer.sv ***
/*
 * Self-checking bench of the power-on reset sequencer.
 * Assumes the board model for the pin and a shortened lock wait.
 */
`timescale 1ns/10ps
module test_power_on_reset_sequencer;
	import prs_pkg::*;

	localparam int LOCK_N = 50;

	logic          ref_clk_in = 1'b0;
	logic          rst_in     = 1'b1;
	wire           pin;
	logic          sys_rst_n;
	logic          pll_pd;
	logic          pll_rst_n;
	logic          chip_rst_n;
	logic          module_rst_n;
	prs_state_type state;
	logic [4:0]    outs;
	int            n_fail = 0;
	int            checked = 0;
	int            cycles = 0;

	assign outs = {module_rst_n, chip_rst_n, pll_rst_n, pll_pd, sys_rst_n};

	always #5 ref_clk_in = ~ref_clk_in;

	prs_board_model prs_board_model_inst (
		.ref_clk_in        (ref_clk_in),
		.external_por_n_out(pin)
	);

	prs_sequencer #(.LOCK_CYCLES(LOCK_N)) prs_sequencer_inst (
		.ref_clk_in       (ref_clk_in),
		.rst_in           (rst_in),
		.external_por_n_in(pin),
		.sys_rst_n_out    (sys_rst_n),
		.pll_pd_out       (pll_pd),
		.pll_rst_n_out    (pll_rst_n),
		.chip_rst_n_out   (chip_rst_n),
		.module_rst_n_out (module_rst_n),
		.seq_state_out    (state)
	);

	task automatic stop_test;
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tick;
		@(posedge ref_clk_in);
		#1;
	endtask

	// counts edges until the chosen output reaches lvl; bounded against a hang
	task automatic edges_until(input int sel, input logic lvl, output int n);
		n = 0;
		do begin
			tick();
			n++;
		end while (outs[sel] !== lvl && n < 3000);
		// a level that never comes counts against the run
		if (outs[sel] !== lvl) begin
			n_fail++;
		end
	endtask

	task automatic check_reset;
		logic [4:0] rst_vec;
		rst_vec = {MOD_RST_N_RST, CHIP_RST_N_RST, PLL_RST_N_RST, PLL_PD_RST, 1'b0};
		check("outputs", 16'(outs), 16'(rst_vec));
		check("state", 16'(state), 16'(ST_HOLD));
	endtask

	task automatic t_sequence;
		int n;
		prs_board_model_inst.drive(1'b1, 1);
		edges_until(0, 1'b1, n);
		check("state pd", 16'(state), 16'(ST_PD));
		check("pd high", 16'(outs), 16'h0003);
		edges_until(1, 1'b0, n);
		check("pd cycles", n[15:0], 16'(PD_CYC));
		check("state pll reset", 16'(state), 16'(ST_PLLRST));
		edges_until(2, 1'b1, n);
		check("pll reset cycles", n[15:0], 16'(PLLRST_CYC));
		check("chip held", 16'(outs), 16'h0005);
		edges_until(3, 1'b1, n);
		check("lock cycles", n[15:0], 16'(LOCK_N));
		check("state clkgen", 16'(state), 16'(ST_CLKGEN));
		check("module held", 16'(outs), 16'h000D);
		edges_until(4, 1'b1, n);
		check("module cycles", n[15:0], 16'(MOD_CYC));
		check("state run", 16'(state), 16'(ST_RUN));
	endtask

	task automatic t_glitch;
		int n;
		prs_board_model_inst.drive(1'b0, 20);
		prs_board_model_inst.drive(1'b1, 1);
		repeat (40) tick();
		check("glitch ignored", 16'(outs), 16'h001D);
		prs_board_model_inst.drive(1'b0, 21);
		edges_until(0, 1'b0, n);
		check_reset();
		// a short high while in reset must not start the sequence either
		prs_board_model_inst.drive(1'b1, 20);
		prs_board_model_inst.drive(1'b0, 1);
		repeat (40) tick();
		check_reset();
		t_sequence();
	endtask

	task automatic t_restart;
		int n;
		prs_board_model_inst.drive(1'b0, 21);
		edges_until(0, 1'b0, n);
		prs_board_model_inst.drive(1'b1, 1);
		edges_until(2, 1'b1, n);
		prs_board_model_inst.drive(1'b0, 21);
		edges_until(0, 1'b0, n);
		check_reset();
		t_sequence();
	endtask

	task automatic t_midreset;
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		tick();
		check_reset();
		@(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_sequence();
	endtask

	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		repeat (11) @(posedge ref_clk_in);
		#1;
		check_reset();
		@(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_sequence();
		t_glitch();
		t_restart();
		t_midreset();
		stop_test();
	end
endmodule
